// >>> src/nha_cfg.svh
`ifndef NHA_CFG_SVH
`define NHA_CFG_SVH

// Clock and link timing
`define NHA_CLK_PERIOD_NS 8
`define NHA_BIT_PERIOD_NS 9440
`define NHA_REPLY_MIN_BITS 9
`define NHA_TIMEOUT_US 5000
`define NHA_WDT_CYCLES 131072

// Contactless page map
`define NHA_PAGE_WRITE_FIRST 8'h02
`define NHA_PAGE_USER_LAST 8'he1
`define NHA_PAGE_CFG_LAST 8'he9
`define NHA_PAGE_SESS0_A 8'hec
`define NHA_PAGE_SESS0_B 8'hed
`define NHA_PAGE_SESS3_A 8'hf8
`define NHA_PAGE_SESS3_B 8'hf9
`define NHA_SECTOR_MAIN 8'h00
`define NHA_SECTOR_SESS 8'h03
`define NHA_MIRROR_SPAN 8'h0f
`define NHA_BLOCK_LAST_PAGE 2'h3
`define NHA_BLOCK_FIRST_PAGE 2'h0

// Reset values
`define NHA_FLAG_RST 1'b0

`endif

// >>> src/nha_pkg.sv
package nha_pkg;
   typedef enum logic [2:0] {
      NHA_CMD_READ, NHA_CMD_FAST_READ, NHA_CMD_WRITE, NHA_CMD_FAST_WRITE,
      NHA_CMD_SECTOR_SELECT, NHA_CMD_HALT, NHA_CMD_OTHER
   } nha_nfc_cmd_e;
   typedef enum logic [1:0] {NHA_RSP_ACK, NHA_RSP_NAK, NHA_RSP_LOCK_NAK} nha_rsp_e;
   typedef enum logic [1:0] {NHA_REG_INVALID, NHA_REG_SESSION, NHA_REG_SRAM, NHA_REG_USER} nha_region_e;
   typedef enum logic [1:0] {NHA_OWN_IDLE, NHA_OWN_HOST, NHA_OWN_RF} nha_owner_e;
endpackage

// >>> src/nha_map_if.sv
`timescale 1ns/1ns
`default_nettype none
interface nha_map_if;
   import nha_pkg::*;
   logic [7:0] page;
   logic [7:0] sector;
   logic is_write;
   logic mirror_on;
   logic [7:0] mirror_block;
   logic [7:0] prot_start;
   logic pwd_enabled;
   logic buf_protect;
   logic authenticated;
   nha_region_e region;
   logic allow;
   modport arb (output page, sector, is_write, mirror_on, mirror_block, prot_start, pwd_enabled,
      buf_protect, authenticated, input region, allow);
   modport map (input page, sector, is_write, mirror_on, mirror_block, prot_start, pwd_enabled,
      buf_protect, authenticated, output region, allow);
endinterface
`default_nettype wire

// >>> src/nha_reply_timer.sv
`timescale 1ns/1ns
`default_nettype none
module nha_reply_timer #(
   parameter int MIN_CYCLES = 10620,
   parameter int TIMEOUT_CYCLES = 625000
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Frame events
   input wire logic frame_end,
   input wire logic reply_sent,
   // Window state
   output logic reply_ok,
   output logic timed_out
);
   localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
   logic [CW-1:0] cnt_q;
   logic running_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         running_q <= 1'b0;
      end else if (frame_end) begin
         cnt_q <= '0;
         running_q <= 1'b1;
      end else if (running_q) begin
         cnt_q <= cnt_q + CW'(1);
         if (reply_sent || timed_out) begin
            running_q <= 1'b0;
         end
      end
   end

   assign reply_ok = running_q && (cnt_q >= CW'(MIN_CYCLES));
   assign timed_out = running_q && (cnt_q == CW'(TIMEOUT_CYCLES - 1));
endmodule
`default_nettype wire

// >>> src/nha_mirror_map.sv
`timescale 1ns/1ns
`include "nha_cfg.svh"
`default_nettype none
module nha_mirror_map (
   // Page lookup
   nha_map_if.map m
);
   import nha_pkg::*;

   function automatic logic in_span(input logic [7:0] p, input logic [7:0] lo, input logic [7:0] hi);
      return (p >= lo) && (p <= hi);
   endfunction

   logic [7:0] sram_lo;
   logic [7:0] sram_hi;
   logic pwd_block;

   assign sram_lo = {m.mirror_block[5:0], `NHA_BLOCK_FIRST_PAGE};
   assign sram_hi = sram_lo + `NHA_MIRROR_SPAN;
   assign pwd_block = m.pwd_enabled && !m.authenticated;

   always_comb begin
      m.region = NHA_REG_INVALID;
      m.allow = 1'b0;
      if (m.sector == `NHA_SECTOR_MAIN) begin
         if (m.mirror_on && in_span(m.page, sram_lo, sram_hi)) begin
            m.region = NHA_REG_SRAM;
            m.allow = !(m.is_write && m.buf_protect && pwd_block);
         end else if (m.page <= `NHA_PAGE_CFG_LAST) begin
            m.region = NHA_REG_USER;
            // protected pages need auth to write
            m.allow = !m.is_write || ((m.page >= `NHA_PAGE_WRITE_FIRST)
               && !(in_span(m.page, m.prot_start, `NHA_PAGE_USER_LAST) && pwd_block));
         end else if (m.page == `NHA_PAGE_SESS0_A || m.page == `NHA_PAGE_SESS0_B) begin
            m.region = NHA_REG_SESSION;
            m.allow = 1'b1;
         end
      end else if (m.sector == `NHA_SECTOR_SESS) begin
         if (m.page == `NHA_PAGE_SESS3_A || m.page == `NHA_PAGE_SESS3_B) begin
            m.region = NHA_REG_SESSION;
            m.allow = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> src/nha_arbiter.sv
// Operation
// - Reply to a reader frame no sooner than nine bit periods; reader times out at 5 ms.
// - Only one interface owns memory at a time, first requester wins.
// - Host and contactless lock flags both read 0 after power-on.
// - Host owning memory: reader may read session registers and sector select; else special NAK.
// - Contactless owning memory: host gets only register access, everything else NACKed.
// - Arbitration applies only while pass-through is disabled.
// - Own address after START in IDLE or HALT sets host lock.
// - Host clears its lock at transaction end, else the watchdog clears it.
// - Reader memory access only while host lock is clear.
// - Valid reader memory command sets contactless lock; host then limited to registers.
// - Contactless lock clears on reset, field loss, HALT or command completion.
// - Reader reading last message page sets the message read flag.
// - Mirror enabled by its setting, never together with pass-through.
// - Mirror maps 64-byte buffer at four times the mirror block setting.
// - Mirror password guarded when authentication and buffer protect are both enabled.
// - Mirror reachable only while main supply is present.
// - Pages from protection start to E1h readable, writable after authentication.
`timescale 1ns/1ns
`include "nha_cfg.svh"
`default_nettype none
module nha_arbiter #(
   parameter int BIT_PERIOD_NS = `NHA_BIT_PERIOD_NS,
   parameter int REPLY_MIN_CYCLES = (`NHA_REPLY_MIN_BITS * BIT_PERIOD_NS + `NHA_CLK_PERIOD_NS - 1)
      / `NHA_CLK_PERIOD_NS,
   parameter int TIMEOUT_CYCLES = (`NHA_TIMEOUT_US * 1000) / `NHA_CLK_PERIOD_NS,
   parameter int WDT_CYCLES = `NHA_WDT_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Power sources
   input wire logic vcc_present,
   input wire logic field_present,
   // Configuration
   input wire logic passthrough_enable,
   input wire logic mirror_enable,
   input wire logic [7:0] mirror_block,
   input wire logic [7:0] message_last_block,
   input wire logic buffer_password_protect,
   input wire logic [7:0] protection_start_page,
   input wire logic pwd_auth_enable,
   input wire logic authenticated,
   // Contactless command side
   input wire logic nfc_idle_or_halt,
   input wire logic nfc_active,
   input wire logic nfc_cmd_valid,
   input wire nha_pkg::nha_nfc_cmd_e nfc_cmd,
   input wire logic [7:0] nfc_page,
   input wire logic [7:0] nfc_end_page,
   input wire logic [7:0] nfc_sector,
   input wire logic nfc_cmd_done,
   output logic nfc_resp_valid,
   output nha_pkg::nha_rsp_e nfc_resp_code,
   output logic nfc_resp_sram,
   // Host side
   input wire logic i2c_start_addr,
   input wire logic i2c_release,
   input wire logic i2c_cmd_valid,
   input wire logic i2c_cmd_reg,
   output logic i2c_ack,
   output logic i2c_nack,
   // Status
   input wire logic message_read_done_clr,
   output logic host_lock_flag,
   output logic contactless_side_lock_flag,
   output logic message_read_done_flag,
   output logic mirror_active
);
   import nha_pkg::*;

   localparam int WW = $clog2(WDT_CYCLES + 1);

   nha_map_if map_bus();

   nha_owner_e owner_q;
   nha_owner_e owner_d;
   logic host_lock_q;
   logic rf_lock_q;
   logic [WW-1:0] wdt_q;
   logic wdt_expired;
   logic arb_on;
   logic mem_cmd;
   logic read_cmd;
   logic write_cmd;
   logic rf_req;
   logic host_req;
   logic rf_clear;
   logic host_clear;
   logic halt_cmd;
   nha_rsp_e rsp_d;
   logic rsp_needed;
   logic rsp_pend_q;
   nha_rsp_e rsp_code_q;
   logic rsp_sram_q;
   logic resp_valid_q;
   nha_rsp_e resp_code_q;
   logic resp_sram_q;
   logic reply_ok;
   logic reply_timeout;
   logic reply_fire;
   logic [7:0] last_page;
   logic msg_set;
   logic msg_done_q;
   logic i2c_ack_q;
   logic i2c_nack_q;

   assign arb_on = !passthrough_enable;

   assign mirror_active = mirror_enable && !passthrough_enable && vcc_present;

   assign map_bus.page = nfc_page;
   assign map_bus.sector = nfc_sector;
   assign map_bus.is_write = write_cmd;
   assign map_bus.mirror_on = mirror_active;
   assign map_bus.mirror_block = mirror_block;
   assign map_bus.prot_start = protection_start_page;
   assign map_bus.pwd_enabled = pwd_auth_enable;
   assign map_bus.buf_protect = buffer_password_protect;
   assign map_bus.authenticated = authenticated;

   nha_mirror_map u_map (
      .m(map_bus.map)
   );

   assign read_cmd = (nfc_cmd == NHA_CMD_READ) || (nfc_cmd == NHA_CMD_FAST_READ);
   assign write_cmd = (nfc_cmd == NHA_CMD_WRITE) || (nfc_cmd == NHA_CMD_FAST_WRITE);
   assign mem_cmd = read_cmd || write_cmd;
   assign halt_cmd = nfc_cmd_valid && (nfc_cmd == NHA_CMD_HALT);

   // reader memory access only while host lock clear
   // valid memory command claims the memory
   assign rf_req = arb_on && nfc_cmd_valid && nfc_active && mem_cmd && map_bus.allow
      && (map_bus.region != NHA_REG_SESSION) && (owner_q != NHA_OWN_HOST);

   // own address after START while reader is idle or halted
   assign host_req = arb_on && i2c_start_addr && nfc_idle_or_halt && (owner_q != NHA_OWN_RF);

   // field loss, HALT or completion ends contactless ownership
   assign rf_clear = !field_present || halt_cmd || nfc_cmd_done;

   // host release or watchdog ends host ownership
   assign wdt_expired = (owner_q == NHA_OWN_HOST) && (wdt_q == WW'(WDT_CYCLES - 1));
   assign host_clear = i2c_release || wdt_expired;

   always_comb begin
      owner_d = owner_q;
      case (owner_q)
         NHA_OWN_IDLE: begin
            if (rf_req) begin
               owner_d = NHA_OWN_RF;
            end else if (host_req) begin
               owner_d = NHA_OWN_HOST;
            end
         end
         NHA_OWN_HOST: begin
            // New address outranks a release in the same cycle
            if (!host_req && host_clear) begin
               owner_d = NHA_OWN_IDLE;
            end
         end
         NHA_OWN_RF: begin
            if (!rf_req && rf_clear) begin
               owner_d = NHA_OWN_IDLE;
            end
         end
         default: begin
            owner_d = NHA_OWN_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         owner_q <= NHA_OWN_IDLE;
         host_lock_q <= `NHA_FLAG_RST;
         rf_lock_q <= `NHA_FLAG_RST;
      end else begin
         owner_q <= owner_d;
         host_lock_q <= (owner_d == NHA_OWN_HOST);
         rf_lock_q <= (owner_d == NHA_OWN_RF);
      end
   end

   // watchdog restarts on each fresh address
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wdt_q <= '0;
      end else if (owner_q != NHA_OWN_HOST || host_req) begin
         wdt_q <= '0;
      end else begin
         wdt_q <= wdt_q + WW'(1);
      end
   end

   // Answer chosen at the frame end, held until the holdoff passes
   always_comb begin
      rsp_d = NHA_RSP_NAK;
      rsp_needed = 1'b0;
      if (nfc_cmd == NHA_CMD_SECTOR_SELECT) begin
         rsp_needed = 1'b1;
         // sector select stays open to the reader
         rsp_d = nfc_active ? NHA_RSP_ACK : NHA_RSP_NAK;
      end else if (mem_cmd) begin
         rsp_needed = 1'b1;
         if (map_bus.region == NHA_REG_SESSION && read_cmd) begin
            rsp_d = NHA_RSP_ACK;
         end else if (owner_q == NHA_OWN_HOST) begin
            rsp_d = NHA_RSP_LOCK_NAK;
         end else if (map_bus.allow && map_bus.region != NHA_REG_SESSION && nfc_active) begin
            rsp_d = NHA_RSP_ACK;
         end
      end
   end

   nha_reply_timer #(
      .MIN_CYCLES(REPLY_MIN_CYCLES),
      .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
   ) u_timer (
      .ref_clk(ref_clk),
      .rst(rst),
      .frame_end(nfc_cmd_valid),
      .reply_sent(reply_fire),
      .reply_ok(reply_ok),
      .timed_out(reply_timeout)
   );

   // never before the holdoff
   // A fresh frame drops a stale answer, which would break its holdoff
   assign reply_fire = rsp_pend_q && reply_ok && !nfc_cmd_valid;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rsp_pend_q <= 1'b0;
         rsp_code_q <= NHA_RSP_NAK;
         rsp_sram_q <= 1'b0;
      end else if (nfc_cmd_valid) begin
         rsp_pend_q <= rsp_needed;
         rsp_code_q <= rsp_d;
         rsp_sram_q <= (map_bus.region == NHA_REG_SRAM);
      end else if (reply_fire || reply_timeout) begin
         // A late answer would be past the reader's timeout
         rsp_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         resp_valid_q <= 1'b0;
         resp_code_q <= NHA_RSP_NAK;
         resp_sram_q <= 1'b0;
      end else begin
         resp_valid_q <= reply_fire;
         if (reply_fire) begin
            resp_code_q <= rsp_code_q;
            resp_sram_q <= rsp_sram_q;
         end
      end
   end

   // last page of the final message block
   assign last_page = {message_last_block[5:0], `NHA_BLOCK_LAST_PAGE};
   assign msg_set = nfc_cmd_valid && read_cmd && (rsp_d == NHA_RSP_ACK)
      && (message_last_block != 8'h00) && (nfc_page <= last_page) && (nfc_end_page >= last_page);

   // Set wins over a clear in the same cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         msg_done_q <= `NHA_FLAG_RST;
      end else if (msg_set) begin
         msg_done_q <= 1'b1;
      end else if (message_read_done_clr) begin
         msg_done_q <= 1'b0;
      end
   end

   // only register access acked while the reader owns memory; memory commands NACKed
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         i2c_ack_q <= 1'b0;
         i2c_nack_q <= 1'b0;
      end else begin
         i2c_ack_q <= i2c_cmd_valid && (i2c_cmd_reg || owner_q != NHA_OWN_RF);
         i2c_nack_q <= i2c_cmd_valid && !i2c_cmd_reg && (owner_q == NHA_OWN_RF);
      end
   end

   assign nfc_resp_valid = resp_valid_q;
   assign nfc_resp_code = resp_code_q;
   assign nfc_resp_sram = resp_sram_q;
   assign i2c_ack = i2c_ack_q;
   assign i2c_nack = i2c_nack_q;
   assign host_lock_flag = host_lock_q;
   assign contactless_side_lock_flag = rf_lock_q;
   assign message_read_done_flag = msg_done_q;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   chk_locks_exclusive: assert property (!(host_lock_q && rf_lock_q))
      else $error("both lock flags set");

   chk_host_lock_set: assert property (host_req && !rf_req |=> host_lock_q && !rf_lock_q)
      else $error("host lock not set after own address");

   chk_rf_lock_set: assert property (rf_req |=> rf_lock_q ##0 !host_lock_q)
      else $error("contactless lock not set after memory command");

   chk_rf_lock_clear: assert property (rf_lock_q && !field_present && !rf_req |=> !rf_lock_q)
      else $error("contactless lock survives field loss");

   chk_wdt_release: assert property (wdt_expired && !host_req |=> !host_lock_q)
      else $error("watchdog did not release host lock");

   chk_host_hold_nak: assert property (nfc_cmd_valid && owner_q == NHA_OWN_HOST && write_cmd
      |=> rsp_pend_q && rsp_code_q == NHA_RSP_LOCK_NAK)
      else $error("reader write not refused while host owns memory");

   chk_reply_holdoff: assert property (nfc_cmd_valid |=> !resp_valid_q [*8])
      else $error("reply sent inside holdoff");

   chk_i2c_refused: assert property (i2c_cmd_valid && !i2c_cmd_reg && rf_lock_q
      |=> i2c_nack_q && !i2c_ack_q)
      else $error("host memory command not refused");

   chk_msg_flag: assert property (msg_set |=> msg_done_q ##1 (msg_done_q || $past(message_read_done_clr)))
      else $error("message read flag not set");

   chk_mirror_window: assert property (mirror_active && nfc_sector == `NHA_SECTOR_MAIN
      && nfc_page >= {mirror_block[5:0], `NHA_BLOCK_FIRST_PAGE}
      && nfc_page <= {mirror_block[5:0], `NHA_BLOCK_FIRST_PAGE} + `NHA_MIRROR_SPAN
      |-> map_bus.region == NHA_REG_SRAM)
      else $error("mirror page not mapped to buffer");

   chk_mirror_power: assert property (!vcc_present |-> map_bus.region != NHA_REG_SRAM)
      else $error("buffer reachable without main supply");

   chk_passthru_idle: assert property (passthrough_enable && !host_lock_q && !rf_lock_q
      |=> !host_lock_q && !rf_lock_q)
      else $error("lock taken in pass-through mode");
endmodule
`default_nettype wire

// >>> bench/nha_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module nha_far_end #(
   parameter int TIMEOUT_CYCLES = 100
) (
   // Clock
   input wire logic ref_clk,
   // Reader side
   output logic nfc_cmd_valid,
   output var nha_pkg::nha_nfc_cmd_e nfc_cmd,
   output logic [7:0] nfc_page,
   output logic [7:0] nfc_end_page,
   output logic [7:0] nfc_sector,
   output logic nfc_cmd_done,
   input wire logic nfc_resp_valid,
   input wire nha_pkg::nha_rsp_e nfc_resp_code,
   input wire logic nfc_resp_sram,
   // Host side
   output logic i2c_start_addr,
   output logic i2c_release,
   output logic i2c_cmd_valid,
   output logic i2c_cmd_reg,
   input wire logic i2c_ack,
   input wire logic i2c_nack
);
   import nha_pkg::*;
   initial begin
      {nfc_cmd_valid, nfc_cmd_done, i2c_start_addr, i2c_release, i2c_cmd_valid, i2c_cmd_reg} = 6'h00;
      nfc_cmd = NHA_CMD_OTHER;
      {nfc_page, nfc_end_page, nfc_sector} = 24'h000000;
   end
   task automatic reader(input nha_nfc_cmd_e c, input logic [7:0] p, input logic [7:0] s,
      input bit wait_rsp, output bit got, output nha_rsp_e code, output logic sram, output int lat);
      got = 1'b0;
      lat = 0;
      code = NHA_RSP_NAK;
      sram = 1'b0;
      nfc_cmd = c;
      nfc_page = p;
      nfc_end_page = p + 8'h03;
      nfc_sector = s;
      nfc_cmd_valid = 1'b1;
      @(posedge ref_clk) #1;
      nfc_cmd_valid = 1'b0;
      // Frame over: page lines no longer meaningful
      nfc_page = ~p;
      nfc_end_page = ~nfc_end_page;
      while (wait_rsp && !got && lat < TIMEOUT_CYCLES) begin
         @(posedge ref_clk) #1;
         lat++;
         if (nfc_resp_valid === 1'b1) begin
            got = 1'b1;
            code = nfc_resp_code;
            sram = nfc_resp_sram;
         end
      end
   endtask
   // Kind: 0 address, 1 release, 2 register cmd, 3 memory cmd
   task automatic host(input int kind, output logic ack, output logic nack);
      i2c_start_addr = (kind == 0);
      i2c_release = (kind == 1);
      i2c_cmd_valid = (kind >= 2);
      i2c_cmd_reg = (kind == 2);
      @(posedge ref_clk) #1;
      ack = i2c_ack;
      nack = i2c_nack;
      {i2c_start_addr, i2c_release, i2c_cmd_valid, i2c_cmd_reg} = 4'h0;
   endtask
   task automatic finish_cmd();
      nfc_cmd_done = 1'b1;
      @(posedge ref_clk) #1;
      nfc_cmd_done = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> bench/tb_nfc_host_memory_arbiter.sv
`timescale 1ns/1ns
`default_nettype none
module tb_nfc_host_memory_arbiter;
   import nha_pkg::*;
   localparam int MIN = 10;
   logic ref_clk, rst, vcc_present, field_present, passthrough_enable, mirror_enable;
   logic buffer_password_protect, pwd_auth_enable, authenticated, nfc_idle_or_halt, nfc_active;
   logic message_read_done_clr, nfc_resp_valid, nfc_resp_sram, i2c_ack, i2c_nack, mirror_active;
   logic host_lock_flag, contactless_side_lock_flag, message_read_done_flag;
   logic nfc_cmd_valid, nfc_cmd_done, i2c_start_addr, i2c_release, i2c_cmd_valid, i2c_cmd_reg;
   logic [7:0] mirror_block, message_last_block, protection_start_page, nfc_page, nfc_end_page, nfc_sector;
   nha_nfc_cmd_e nfc_cmd;
   nha_rsp_e nfc_resp_code, code;
   int fail_count, n_checks, lat, m_host;
   bit got;
   logic sram, a, n;
   logic [31:0] lfsr_q;
   logic [7:0] pg;
   logic [7:0] edge_pages [5] = '{8'h3f, 8'h40, 8'he1, 8'he2, 8'h01};

   nha_arbiter #(.REPLY_MIN_CYCLES(MIN), .TIMEOUT_CYCLES(100), .WDT_CYCLES(50)) dut (
      .ref_clk, .rst, .vcc_present, .field_present, .passthrough_enable, .mirror_enable,
      .mirror_block, .message_last_block, .buffer_password_protect, .protection_start_page,
      .pwd_auth_enable, .authenticated, .nfc_idle_or_halt, .nfc_active, .nfc_cmd_valid, .nfc_cmd,
      .nfc_page, .nfc_end_page, .nfc_sector, .nfc_cmd_done, .nfc_resp_valid, .nfc_resp_code,
      .nfc_resp_sram, .i2c_start_addr, .i2c_release, .i2c_cmd_valid, .i2c_cmd_reg, .i2c_ack,
      .i2c_nack, .message_read_done_clr, .host_lock_flag, .contactless_side_lock_flag,
      .message_read_done_flag, .mirror_active
   );
   nha_far_end #(.TIMEOUT_CYCLES(100)) far (
      .ref_clk, .nfc_cmd_valid, .nfc_cmd, .nfc_page, .nfc_end_page, .nfc_sector, .nfc_cmd_done,
      .nfc_resp_valid, .nfc_resp_code, .nfc_resp_sram, .i2c_start_addr, .i2c_release,
      .i2c_cmd_valid, .i2c_cmd_reg, .i2c_ack, .i2c_nack
   );

   initial ref_clk = 1'b0;
   always #4 ref_clk = ~ref_clk;

   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Reference reply for a reader command
   function automatic nha_rsp_e model_rsp(input nha_nfc_cmd_e c, input logic [7:0] p, input logic [7:0] s);
      bit sess, mir, prot;
      sess = (s == 8'h00 && (p == 8'hec || p == 8'hed)) || (s == 8'h03 && (p == 8'hf8 || p == 8'hf9));
      mir = mirror_enable && !passthrough_enable && vcc_present && p >= {mirror_block[5:0], 2'b00}
         && p <= {mirror_block[5:0], 2'b00} + 8'h0f;
      prot = pwd_auth_enable && !authenticated
         && ((mir && buffer_password_protect) || (p >= protection_start_page && p <= 8'he1));
      if (c == NHA_CMD_SECTOR_SELECT) return nfc_active ? NHA_RSP_ACK : NHA_RSP_NAK;
      if ((c == NHA_CMD_READ || c == NHA_CMD_FAST_READ) && sess) return NHA_RSP_ACK;
      if (m_host != 0) return NHA_RSP_LOCK_NAK;
      if (s != 8'h00 || p > 8'he9 || !nfc_active) return NHA_RSP_NAK;
      if ((c == NHA_CMD_WRITE || c == NHA_CMD_FAST_WRITE) && (p < 8'h02 || prot)) return NHA_RSP_NAK;
      return NHA_RSP_ACK;
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic rq(input nha_nfc_cmd_e c, input logic [7:0] p, input logic [7:0] s, input logic e_sram);
      nha_rsp_e exp;
      exp = model_rsp(c, p, s);
      far.reader(c, p, s, 1'b1, got, code, sram, lat);
      chk("reply seen", 1, got);
      if (!got) end_of_test();
      chk("reply code", 8'(exp), 8'(code));
      chk("reply sram", e_sram, sram);
      chk("reply not early", 1, lat >= MIN + 1);
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask

   initial begin
      fail_count = 0;
      n_checks = 0;
      m_host = 0;
      lfsr_q = 32'h331035f7;
      {rst, vcc_present, field_present, passthrough_enable, mirror_enable} = 5'b11100;
      {buffer_password_protect, pwd_auth_enable, authenticated, nfc_idle_or_halt} = 4'h0;
      {nfc_active, message_read_done_clr} = 2'b10;
      {mirror_block, message_last_block, protection_start_page} = {8'h01, 8'h00, 8'hff};
      tick(5);
      rst = 1'b0;
      chk("host lock", 0, host_lock_flag);
      chk("rf lock", 0, contactless_side_lock_flag);
      nfc_idle_or_halt = 1'b1;
      far.host(0, a, n);
      m_host = 1;
      nfc_idle_or_halt = 1'b0;
      chk("host lock", 1, host_lock_flag);
      rq(NHA_CMD_READ, 8'h04, 8'h00, 0);
      chk("rf lock", 0, contactless_side_lock_flag);
      rq(NHA_CMD_READ, 8'hec, 8'h00, 0);
      rq(NHA_CMD_READ, 8'hf8, 8'h03, 0);
      rq(NHA_CMD_SECTOR_SELECT, 8'h00, 8'h00, 0);
      rq(NHA_CMD_FAST_WRITE, 8'h30, 8'h00, 0);
      far.host(3, a, n);
      chk("host ack", 1, a);
      far.host(1, a, n);
      m_host = 0;
      chk("host lock", 0, host_lock_flag);
      nfc_idle_or_halt = 1'b1;
      far.host(0, a, n);
      nfc_idle_or_halt = 1'b0;
      lat = 0;
      while (host_lock_flag === 1'b1 && lat < 60) begin
         tick(1);
         lat++;
      end
      chk("watchdog release", 1, lat == 50);
      if (lat == 60) end_of_test();
      $display("host lock test done");
      message_last_block = 8'h01;
      rq(NHA_CMD_READ, 8'h04, 8'h00, 0);
      chk("rf lock", 1, contactless_side_lock_flag);
      chk("message read", 1, message_read_done_flag);
      nfc_idle_or_halt = 1'b1;
      far.host(0, a, n);
      chk("host lock", 0, host_lock_flag);
      far.host(3, a, n);
      chk("host nack", 1, n);
      far.host(2, a, n);
      chk("host reg ack", 1, a);
      far.finish_cmd();
      chk("rf lock", 0, contactless_side_lock_flag);
      message_read_done_clr = 1'b1;
      tick(1);
      message_read_done_clr = 1'b0;
      chk("message read", 0, message_read_done_flag);
      rq(NHA_CMD_READ, 8'h10, 8'h00, 0);
      field_present = 1'b0;
      tick(1);
      field_present = 1'b1;
      chk("rf lock", 0, contactless_side_lock_flag);
      rq(NHA_CMD_READ, 8'h10, 8'h00, 0);
      far.reader(NHA_CMD_HALT, 8'h00, 8'h00, 0, got, code, sram, lat);
      tick(1);
      chk("rf lock", 0, contactless_side_lock_flag);
      fork
         far.host(0, a, n);
         rq(NHA_CMD_READ, 8'h20, 8'h00, 0);
      join
      chk("host lock", 0, host_lock_flag);
      chk("rf lock", 1, contactless_side_lock_flag);
      far.finish_cmd();
      passthrough_enable = 1'b1;
      far.host(0, a, n);
      chk("host lock", 0, host_lock_flag);
      {passthrough_enable, nfc_idle_or_halt} = 2'b00;
      $display("contactless lock test done");
      for (int i = 0; i < 8; i++) begin
         {vcc_present, mirror_enable, passthrough_enable} = 3'(i);
         #1;
         chk("mirror active", 8'(i == 6), mirror_active);
      end
      passthrough_enable = 1'b0;
      rq(NHA_CMD_WRITE, 8'h04, 8'h00, 1);
      far.finish_cmd();
      rq(NHA_CMD_WRITE, 8'h13, 8'h00, 1);
      far.finish_cmd();
      rq(NHA_CMD_WRITE, 8'h14, 8'h00, 0);
      far.finish_cmd();
      {buffer_password_protect, pwd_auth_enable} = 2'b11;
      rq(NHA_CMD_WRITE, 8'h08, 8'h00, 1);
      far.finish_cmd();
      vcc_present = 1'b0;
      rq(NHA_CMD_WRITE, 8'h08, 8'h00, 0);
      far.finish_cmd();
      {vcc_present, mirror_enable} = 2'b10;
      $display("mirror test done");
      protection_start_page = 8'h40;
      rq(NHA_CMD_READ, 8'hea, 8'h00, 0);
      foreach (edge_pages[i]) begin
         rq(NHA_CMD_WRITE, edge_pages[i], 8'h00, 0);
         far.finish_cmd();
      end
      for (int i = 0; i < 24; i++) begin
         lfsr_q = next_rand(lfsr_q);
         authenticated = lfsr_q[0];
         nfc_active = lfsr_q[1];
         pg = 8'h14 + 8'(lfsr_q[15:8] % 8'hce);
         rq(nha_nfc_cmd_e'(lfsr_q[17:16]), pg, 8'h00, 0);
         far.finish_cmd();
      end
      nfc_active = 1'b0;
      rq(NHA_CMD_SECTOR_SELECT, 8'h00, 8'h00, 0);
      $display("protection test done");
      end_of_test();
   end
endmodule
`default_nettype wire
